// [bench/test_global_interrupt_mask_bank.sv]
// Self-checking testbench for the global interrupt mask bank
`timescale 1ns/1ps
`default_nettype none
module test_global_interrupt_mask_bank;
    import gimb_pkg::*;

    // ------------------------------------------------------------
    // Signals and bookkeeping
    // ------------------------------------------------------------
    typedef struct packed {
        logic              wr;
        logic [DATA_W-1:0] rd;
        logic              err;
    } gimb_note_t;

    logic              pclk;
    logic              presetn;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
    logic [3:0]        pstrb;
    logic [DATA_W-1:0] prdata;
    logic              pready;
    logic              pslverr;
    logic [CH_N-1:0]   framer_irq;
    logic [CH_N-1:0]   tester_irq;
    logic [CH_N-1:0]   line_irq;
    logic [CH_N-1:0]   gpio_pin;
    logic              irq;
    gimb_note_t        notes[$];
    gimb_note_t        cur;
    int                err_count = 0;
    int                n_tests = 0;
    int                cycles = 0;
    logic [IDX_W-1:0]  en_idx[6];
    logic [IDX_W-1:0]  st_idx[6];
    logic [REG_W-1:0]  shadow[6];

    gimb_top i_gimb_top (
        .pclk       (pclk),
        .presetn    (presetn),
        .psel       (psel),
        .penable    (penable),
        .pwrite     (pwrite),
        .paddr      (paddr),
        .pwdata     (pwdata),
        .pstrb      (pstrb),
        .prdata     (prdata),
        .pready     (pready),
        .pslverr    (pslverr),
        .framer_irq (framer_irq),
        .tester_irq (tester_irq),
        .line_irq   (line_irq),
        .gpio_pin   (gpio_pin),
        .irq        (irq)
    );

    // 20 MHz clock
    initial pclk = 1'b0;
    always #25 pclk = ~pclk;

    // ------------------------------------------------------------
    // Compare, verdict and bus tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [DATA_W-1:0] exp,
                       input logic [DATA_W-1:0] got);
        n_tests++;
        if (got !== exp)
        begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // One APB transfer; expectation queued for the monitor
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] addr,
                       input logic [DATA_W-1:0] wdata, input logic [3:0] strb,
                       input logic [DATA_W-1:0] exp_rd, input logic exp_err);
        int n;
        n = 0;
        notes.push_back('{wr, exp_rd, exp_err});
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= wdata;
        pstrb   <= strb;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 16)
        begin
            n++;
            @(posedge pclk);
        end
        if (n == 16)
            chk("pready wait", 32'h1, 32'h0);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [IDX_W-1:0] idx, input logic [REG_W-1:0] exp);
        apb(1'b0, {idx, 2'h0}, 32'h0000_0000, 4'hf, {24'h00_0000, exp}, 1'b0);
    endtask

    // Upper write bits are random; only the low byte may count
    task automatic wr(input logic [IDX_W-1:0] idx, input logic [REG_W-1:0] data);
        logic [DATA_W-1:0] r;
        r = $urandom;
        r[7:0] = data;
        apb(1'b1, {idx, 2'h0}, r, 4'hf, 32'h0000_0000, 1'b0);
    endtask

    // One-cycle interrupt request from one source class
    task automatic pulse(input int c, input int ch);
        @(posedge pclk);
        case (c)
            0: framer_irq <= 16'h0001 << ch;
            1: tester_irq <= 16'h0001 << ch;
            default: line_irq <= 16'h0001 << ch;
        endcase
        @(posedge pclk);
        framer_irq <= 16'h0000;
        tester_irq <= 16'h0000;
        line_irq   <= 16'h0000;
    endtask

    // ------------------------------------------------------------
    // Monitor and timeout
    // ------------------------------------------------------------
    // Completed transfers are matched against the oldest note
    always @(posedge pclk)
    begin
        if (presetn === 1'b1 && psel === 1'b1 && penable === 1'b1 && pready === 1'b1)
        begin
            if (notes.size() == 0)
                chk("unexpected transfer", 32'h1, 32'h0);
            else
            begin
                cur = notes.pop_front();
                chk("pslverr", {31'h0, cur.err}, {31'h0, pslverr});
                if (!cur.wr)
                    chk("prdata", cur.rd, prdata);
            end
        end
    end

    // Hang guard, far above the expected run length
    always @(posedge pclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            chk("timeout", 32'h0, 32'h1);
            results();
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        int               ch;
        int               k;
        logic [CH_N-1:0]  gp;
        logic [REG_W-1:0] bv;
        psel       = 1'b0;
        penable    = 1'b0;
        pwrite     = 1'b0;
        paddr      = 16'h0000;
        pwdata     = 32'h0000_0000;
        pstrb      = 4'h0;
        framer_irq = 16'h0000;
        tester_irq = 16'h0000;
        line_irq   = 16'h0000;
        gpio_pin   = 16'h0000;
        presetn    = 1'b0;
        en_idx = '{IDX_FRM_EN_LO, IDX_FRM_EN_HI, IDX_TST_EN_LO,
                   IDX_TST_EN_HI, IDX_LIN_EN_LO, IDX_LIN_EN_HI};
        st_idx = '{IDX_FRM_ST_LO, IDX_FRM_ST_HI, IDX_TST_ST_LO,
                   IDX_TST_ST_HI, IDX_LIN_ST_LO, IDX_LIN_ST_HI};
        void'($urandom(75205));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values of the enables, interrupt quiet
        rd(IDX_FRM_EN_LO, 8'h00);
        rd(IDX_FRM_EN_HI, 8'h00);
        rd(IDX_TST_EN_LO, 8'h00);
        rd(IDX_TST_EN_HI, 8'h00);
        rd(IDX_LIN_EN_LO, 8'h00);
        rd(IDX_LIN_EN_HI, 8'h00);
        chk("irq after reset", 32'h0, {31'h0, irq});
        $display("test reset values done");
        // Random writes to every enable, then back-to-back readback
        for (k = 0; k < 6; k++)
        begin
            shadow[k] = $urandom;
            wr(en_idx[k], shadow[k]);
        end
        rd(IDX_FRM_EN_LO, shadow[0]);
        rd(IDX_FRM_EN_HI, shadow[1]);
        rd(IDX_TST_EN_LO, shadow[2]);
        rd(IDX_TST_EN_HI, shadow[3]);
        rd(IDX_LIN_EN_LO, shadow[4]);
        rd(IDX_LIN_EN_HI, shadow[5]);
        // Strobe off, misaligned and unmapped accesses change nothing
        apb(1'b1, {IDX_FRM_EN_LO, 2'h0}, {24'h0, ~shadow[0]}, 4'he, 32'h0, 1'b0);
        rd(IDX_FRM_EN_LO, shadow[0]);
        apb(1'b1, {IDX_LIN_EN_HI, 2'h2}, {24'h0, ~shadow[5]}, 4'hf, 32'h0, 1'b1);
        rd(IDX_LIN_EN_HI, shadow[5]);
        apb(1'b0, 16'h0400, 32'h0, 4'hf, 32'h0, 1'b1);
        $display("test enable access done");
        // Pin levels, read-only pin registers
        gp = $urandom;
        gpio_pin <= gp;
        repeat (4) @(posedge pclk);
        rd(IDX_PIN_LO, gp[7:0]);
        rd(IDX_PIN_HI, gp[15:8]);
        apb(1'b1, {IDX_PIN_HI, 2'h0}, {24'h0, ~gp[15:8]}, 4'hf, 32'h0, 1'b1);
        rd(IDX_PIN_HI, gp[15:8]);
        $display("test pin levels done");
        // Sticky status, masking and interrupt output per class
        for (k = 0; k < 6; k++)
            wr(en_idx[k], 8'h00);
        for (int c = 0; c < 3; c++)
        begin
            for (int j = 0; j < 2; j++)
            begin
                ch = $urandom_range(CH_N - 1, 0);
                k  = 2 * c + ch / 8;
                bv = 8'h01 << (ch % 8);
                pulse(c, ch);
                repeat (3) @(negedge pclk);
                chk("irq masked", 32'h0, {31'h0, irq});
                rd(st_idx[k], bv);
                wr(en_idx[k], bv);
                repeat (3) @(negedge pclk);
                chk("irq enabled", 32'h1, {31'h0, irq});
                wr(en_idx[k], ~bv);
                repeat (3) @(negedge pclk);
                chk("irq other bits", 32'h0, {31'h0, irq});
                wr(st_idx[k], bv);
                rd(st_idx[k], 8'h00);
                wr(en_idx[k], 8'h00);
            end
        end
        $display("test interrupt path done");
        repeat (2) @(posedge pclk);
        results();
    end
endmodule
`default_nettype wire

// [rtl/gimb_sync.sv]
// Two-flop synchroniser for the general-purpose pin levels
`timescale 1ns/1ps
`default_nettype none
module gimb_sync
    import gimb_pkg::*;
(
    input  wire logic     pclk,
    input  wire logic     presetn,
    gimb_pin_if.sync_side pins
);

    // ------------------------------------------------------------
    // Synchroniser stages
    // ------------------------------------------------------------
    logic [CH_N-1:0] meta_q;
    logic [CH_N-1:0] sync_q;

    // First stage is read only by the second stage
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta_q <= RST_BANK;
            sync_q <= RST_BANK;
        end
        else
        begin
            meta_q <= pins.raw;
            sync_q <= meta_q;
        end
    end

    assign pins.synced = sync_q;

endmodule
`default_nettype wire

// [rtl/gimb_top.sv]
// Global interrupt mask bank with APB register access
//
// Notes on behaviour
// (R1) Framer enable register, channels 1-8; bit k enables channel k+1.
// (R2) Framer enable register, channels 9-16; bit 7 is channel 16; reset zero.
// (R3) Tester enable register, channels 1-8; 1 enables, 0 masks; reset zero.
// (R4) Tester enable register, channels 9-16; bit 7 is tester 16; reset zero.
// (R5) Line enable register, channels 1-8; 1 enables, 0 masks; reset zero.
// (R6) Line enable register, channels 9-16; bit 7 is line 16; reset zero.
// (R7) Pin status low reads live level of pins 1-8, bit 0 is pin 1.
// (R8) Pin status high reads live level of pins 9-16, bit 0 is pin 9.
// (R9) A source asserting its interrupt sets its sticky global status bit.
// (R10) Interrupt output high only while a set status bit is enabled.
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module gimb_top
    import gimb_pkg::*;
(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [DATA_W-1:0] pwdata,
    input  wire logic [3:0]        pstrb,
    output logic      [DATA_W-1:0] prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic [CH_N-1:0]   framer_irq,
    input  wire logic [CH_N-1:0]   tester_irq,
    input  wire logic [CH_N-1:0]   line_irq,
    input  wire logic [CH_N-1:0]   gpio_pin,
    output logic                   irq
);

    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------

    // Byte write into one half of a 16-bit bank
    function automatic logic [CH_N-1:0] wr_half(
        input logic [CH_N-1:0]  old,
        input logic             lo,
        input logic             hi,
        input logic [REG_W-1:0] data
    );
        logic [CH_N-1:0] r;
        r = old;
        if (lo)
            r[REG_W-1:0] = data;
        if (hi)
            r[CH_N-1:REG_W] = data;
        return r;
    endfunction

    // Sticky status update; a new event wins over a clear
    function automatic logic [CH_N-1:0] sticky(
        input logic [CH_N-1:0] old,
        input logic [CH_N-1:0] clr,
        input logic [CH_N-1:0] set
    );
        return (old & ~clr) | set;
    endfunction

    // Spread a byte clear mask into one half of a bank
    function automatic logic [CH_N-1:0] clr_mask(
        input logic             lo,
        input logic             hi,
        input logic [REG_W-1:0] data
    );
        logic [CH_N-1:0] r;
        r = RST_BANK;
        if (lo)
            r[REG_W-1:0] = data;
        if (hi)
            r[CH_N-1:REG_W] = data;
        return r;
    endfunction

    // ------------------------------------------------------------
    // Pin synchroniser
    // ------------------------------------------------------------
    gimb_pin_if pin_bus ();

    assign pin_bus.raw = gpio_pin;

    gimb_sync u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .pins    (pin_bus.sync_side)
    );

    logic [CH_N-1:0] pin_lvl;
    assign pin_lvl = pin_bus.synced;

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    logic [IDX_W-1:0] idx;
    logic             aligned;
    logic             setup;
    logic             access;
    logic             wr_en;
    logic [REG_W-1:0] wbyte;
    logic             hit_frm_st_lo;
    logic             hit_frm_st_hi;
    logic             hit_tst_st_lo;
    logic             hit_tst_st_hi;
    logic             hit_lin_st_lo;
    logic             hit_lin_st_hi;
    logic             hit_frm_en_lo;
    logic             hit_frm_en_hi;
    logic             hit_tst_en_lo;
    logic             hit_tst_en_hi;
    logic             hit_lin_en_lo;
    logic             hit_lin_en_hi;
    logic             hit_pin_lo;
    logic             hit_pin_hi;
    logic             mapped;
    logic             read_only;

    // Index and phase decode
    assign idx     = paddr[ADDR_W-1:IDX_LSB];
    assign aligned = (paddr[IDX_LSB-1:0] == ALIGN_OK);
    assign setup   = psel & ~penable;
    assign access  = psel & penable;
    assign wbyte   = pwdata[REG_W-1:0];

    // Register hits
    assign hit_frm_st_lo = aligned & (idx == IDX_FRM_ST_LO);
    assign hit_frm_st_hi = aligned & (idx == IDX_FRM_ST_HI);
    assign hit_tst_st_lo = aligned & (idx == IDX_TST_ST_LO);
    assign hit_tst_st_hi = aligned & (idx == IDX_TST_ST_HI);
    assign hit_lin_st_lo = aligned & (idx == IDX_LIN_ST_LO);
    assign hit_lin_st_hi = aligned & (idx == IDX_LIN_ST_HI);
    assign hit_frm_en_lo = aligned & (idx == IDX_FRM_EN_LO);
    assign hit_frm_en_hi = aligned & (idx == IDX_FRM_EN_HI);
    assign hit_tst_en_lo = aligned & (idx == IDX_TST_EN_LO);
    assign hit_tst_en_hi = aligned & (idx == IDX_TST_EN_HI);
    assign hit_lin_en_lo = aligned & (idx == IDX_LIN_EN_LO);
    assign hit_lin_en_hi = aligned & (idx == IDX_LIN_EN_HI);
    assign hit_pin_lo    = aligned & (idx == IDX_PIN_LO);
    assign hit_pin_hi    = aligned & (idx == IDX_PIN_HI);
    assign read_only     = hit_pin_lo | hit_pin_hi;
    assign mapped = hit_frm_st_lo | hit_frm_st_hi | hit_tst_st_lo | hit_tst_st_hi
                  | hit_lin_st_lo | hit_lin_st_hi | hit_frm_en_lo | hit_frm_en_hi
                  | hit_tst_en_lo | hit_tst_en_hi | hit_lin_en_lo | hit_lin_en_hi
                  | read_only;

    // Writes act in the access phase on a mapped writable byte lane 0
    assign wr_en = access & pwrite & pstrb[0] & mapped & ~read_only;

    // ------------------------------------------------------------
    // Enable banks
    // ------------------------------------------------------------
    logic [CH_N-1:0] frm_en_q;
    logic [CH_N-1:0] frm_en_d;
    logic [CH_N-1:0] tst_en_q;
    logic [CH_N-1:0] tst_en_d;
    logic [CH_N-1:0] lin_en_q;
    logic [CH_N-1:0] lin_en_d;

    // Next values of the enable banks
    assign frm_en_d = wr_half(frm_en_q, wr_en & hit_frm_en_lo,
                              wr_en & hit_frm_en_hi, wbyte); // R1 R2
    assign tst_en_d = wr_half(tst_en_q, wr_en & hit_tst_en_lo,
                              wr_en & hit_tst_en_hi, wbyte); // R3 R4
    assign lin_en_d = wr_half(lin_en_q, wr_en & hit_lin_en_lo,
                              wr_en & hit_lin_en_hi, wbyte); // R5 R6

    // Enable registers, all masked after reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            frm_en_q <= RST_BANK; // R2
            tst_en_q <= RST_BANK; // R3 R4
            lin_en_q <= RST_BANK; // R5 R6
        end
        else
        begin
            frm_en_q <= frm_en_d;
            tst_en_q <= tst_en_d;
            lin_en_q <= lin_en_d;
        end
    end

    // ------------------------------------------------------------
    // Sticky status banks
    // ------------------------------------------------------------
    logic [CH_N-1:0] frm_st_q;
    logic [CH_N-1:0] frm_st_d;
    logic [CH_N-1:0] tst_st_q;
    logic [CH_N-1:0] tst_st_d;
    logic [CH_N-1:0] lin_st_q;
    logic [CH_N-1:0] lin_st_d;

    // Write one to clear; an asserted source keeps its bit set
    assign frm_st_d = sticky(frm_st_q, clr_mask(wr_en & hit_frm_st_lo,
                             wr_en & hit_frm_st_hi, wbyte), framer_irq); // R9
    assign tst_st_d = sticky(tst_st_q, clr_mask(wr_en & hit_tst_st_lo,
                             wr_en & hit_tst_st_hi, wbyte), tester_irq); // R9
    assign lin_st_d = sticky(lin_st_q, clr_mask(wr_en & hit_lin_st_lo,
                             wr_en & hit_lin_st_hi, wbyte), line_irq); // R9

    // Status registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            frm_st_q <= RST_BANK;
            tst_st_q <= RST_BANK;
            lin_st_q <= RST_BANK;
        end
        else
        begin
            frm_st_q <= frm_st_d;
            tst_st_q <= tst_st_d;
            lin_st_q <= lin_st_d;
        end
    end

    // ------------------------------------------------------------
    // Interrupt output
    // ------------------------------------------------------------
    logic irq_d;
    logic irq_q;

    // Any set status bit whose enable is one
    assign irq_d = |((frm_st_q & frm_en_q) | (tst_st_q & tst_en_q)
                   | (lin_st_q & lin_en_q)); // R10

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_q <= 1'b0;
        else
            irq_q <= irq_d; // R10
    end

    assign irq = irq_q;

    // ------------------------------------------------------------
    // Read data and error response
    // ------------------------------------------------------------
    logic [REG_W-1:0]  rbyte;
    logic [DATA_W-1:0] rdata_q;
    logic              err_q;

    // Read selection; unmapped addresses read zero
    assign rbyte = hit_frm_st_lo ? frm_st_q[REG_W-1:0]
                 : hit_frm_st_hi ? frm_st_q[CH_N-1:REG_W]
                 : hit_tst_st_lo ? tst_st_q[REG_W-1:0]
                 : hit_tst_st_hi ? tst_st_q[CH_N-1:REG_W]
                 : hit_lin_st_lo ? lin_st_q[REG_W-1:0]
                 : hit_lin_st_hi ? lin_st_q[CH_N-1:REG_W]
                 : hit_frm_en_lo ? frm_en_q[REG_W-1:0]
                 : hit_frm_en_hi ? frm_en_q[CH_N-1:REG_W]
                 : hit_tst_en_lo ? tst_en_q[REG_W-1:0]
                 : hit_tst_en_hi ? tst_en_q[CH_N-1:REG_W]
                 : hit_lin_en_lo ? lin_en_q[REG_W-1:0]
                 : hit_lin_en_hi ? lin_en_q[CH_N-1:REG_W]
                 : hit_pin_lo    ? pin_lvl[REG_W-1:0]    // R7
                 : hit_pin_hi    ? pin_lvl[CH_N-1:REG_W] // R8
                 : {REG_W{1'b0}};

    // Read data captured in setup, error flag for the access phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rdata_q <= RST_RDATA;
            err_q   <= 1'b0;
        end
        else if (setup)
        begin
            rdata_q <= pwrite ? RST_RDATA : {{(DATA_W-REG_W){1'b0}}, rbyte}; // R7 R8
            err_q   <= ~mapped | (pwrite & read_only);
        end
    end

    // Zero-wait slave
    assign prdata  = rdata_q;
    assign pready  = 1'b1;
    assign pslverr = access & err_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_frm_lo_write;
        @(posedge pclk) disable iff (!presetn)
        (wr_en & hit_frm_en_lo) |=> (frm_en_q[REG_W-1:0] == $past(pwdata[REG_W-1:0]))
                                    && $stable(frm_en_q[CH_N-1:REG_W]);
    endproperty
    a_frm_lo_write: assert property (p_frm_lo_write) // R1
        else $error("framer low enable not written");

    property p_frm_hi_write;
        @(posedge pclk) disable iff (!presetn)
        (wr_en & hit_frm_en_hi) |=> (frm_en_q[CH_N-1:REG_W] == $past(pwdata[REG_W-1:0]))
                                    && $stable(frm_en_q[REG_W-1:0]);
    endproperty
    a_frm_hi_write: assert property (p_frm_hi_write) // R2
        else $error("framer high enable not written");

    property p_tst_lo_rd;
        @(posedge pclk) disable iff (!presetn)
        (setup & ~pwrite & hit_tst_en_lo) |=> (prdata[REG_W-1:0] == tst_en_q[REG_W-1:0]);
    endproperty
    a_tst_lo_rd: assert property (p_tst_lo_rd) // R3
        else $error("tester low enable read mismatch");

    property p_tst_hold;
        @(posedge pclk) disable iff (!presetn)
        !(wr_en & (hit_tst_en_lo | hit_tst_en_hi)) |=> $stable(tst_en_q);
    endproperty
    a_tst_hold: assert property (p_tst_hold) // R4
        else $error("tester enable changed without a write");

    property p_lin_lo_write;
        @(posedge pclk) disable iff (!presetn)
        (wr_en & hit_lin_en_lo) |=> (lin_en_q[REG_W-1:0] == $past(pwdata[REG_W-1:0]))
                                    && $stable(lin_en_q[CH_N-1:REG_W]);
    endproperty
    a_lin_lo_write: assert property (p_lin_lo_write) // R5
        else $error("line low enable not written");

    property p_lin_hi_write;
        @(posedge pclk) disable iff (!presetn)
        (wr_en & hit_lin_en_hi) |=> (lin_en_q[CH_N-1:REG_W] == $past(pwdata[REG_W-1:0]));
    endproperty
    a_lin_hi_write: assert property (p_lin_hi_write) // R6
        else $error("line high enable not written");

    property p_pin_lo_rd;
        @(posedge pclk) disable iff (!presetn)
        (setup & ~pwrite & hit_pin_lo) |=> (prdata[REG_W-1:0] == $past(pin_lvl[REG_W-1:0]));
    endproperty
    a_pin_lo_rd: assert property (p_pin_lo_rd) // R7
        else $error("pin low read mismatch");

    property p_pin_hi_rd;
        @(posedge pclk) disable iff (!presetn)
        (setup & ~pwrite & hit_pin_hi) |=> (prdata[REG_W-1:0] == $past(pin_lvl[CH_N-1:REG_W]));
    endproperty
    a_pin_hi_rd: assert property (p_pin_hi_rd) // R8
        else $error("pin high read mismatch");

    property p_event_sets;
        @(posedge pclk) disable iff (!presetn)
        (line_irq != RST_BANK) |=> ((lin_st_q & $past(line_irq)) == $past(line_irq));
    endproperty
    a_event_sets: assert property (p_event_sets) // R9
        else $error("line event lost");

    property p_irq_level;
        @(posedge pclk) disable iff (!presetn)
        ##1 (irq == $past(|((frm_st_q & frm_en_q) | (tst_st_q & tst_en_q)
                            | (lin_st_q & lin_en_q))));
    endproperty
    a_irq_level: assert property (p_irq_level) // R10
        else $error("interrupt output disagrees with status and enables");

endmodule
`default_nettype wire

// [shared/gimb_pin_if.sv]
// Interface carrying raw and synchronised pin levels
`timescale 1ns/1ps
`default_nettype none
interface gimb_pin_if;
    import gimb_pkg::*;
    logic [CH_N-1:0] raw;
    logic [CH_N-1:0] synced;
    modport sync_side (input raw, output synced);
    modport user_side (output raw, input synced);
endinterface
`default_nettype wire

// [shared/gimb_pkg.sv]
// Constants and register map of the global interrupt mask bank
package gimb_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int ADDR_W = 16;
    localparam int DATA_W = 32;
    localparam int REG_W  = 8;
    localparam int CH_N   = 16;
    localparam int IDX_W  = 14;
    localparam int IDX_LSB = 2;
    localparam int SYNC_N = 2;

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [IDX_W-1:0] IDX_FRM_ST_LO = 14'h00f9;
    localparam logic [IDX_W-1:0] IDX_FRM_ST_HI = 14'h20f9;
    localparam logic [IDX_W-1:0] IDX_TST_ST_LO = 14'h00fa;
    localparam logic [IDX_W-1:0] IDX_TST_ST_HI = 14'h20fa;
    localparam logic [IDX_W-1:0] IDX_LIN_ST_LO = 14'h00fb;
    localparam logic [IDX_W-1:0] IDX_LIN_ST_HI = 14'h20fb;
    localparam logic [IDX_W-1:0] IDX_FRM_EN_LO = 14'h00fc;
    localparam logic [IDX_W-1:0] IDX_FRM_EN_HI = 14'h20fc;
    localparam logic [IDX_W-1:0] IDX_TST_EN_LO = 14'h00fd;
    localparam logic [IDX_W-1:0] IDX_TST_EN_HI = 14'h20fd;
    localparam logic [IDX_W-1:0] IDX_LIN_EN_LO = 14'h00fe;
    localparam logic [IDX_W-1:0] IDX_LIN_EN_HI = 14'h20fe;
    localparam logic [IDX_W-1:0] IDX_PIN_LO    = 14'h00ff;
    localparam logic [IDX_W-1:0] IDX_PIN_HI    = 14'h20ff;

    // ------------------------------------------------------------
    // Reset values and byte alignment
    // ------------------------------------------------------------
    localparam logic [CH_N-1:0]   RST_BANK  = 16'h0000;
    localparam logic [DATA_W-1:0] RST_RDATA = 32'h0000_0000;
    localparam logic [1:0]        ALIGN_OK  = 2'h0;

endpackage
